// [logic/ampctl_defines.vh]
// Constants for the two-wire control port with strap-selected address and slot
// Notes on behaviour
// - Port ready within 12 ms after reset
// - Upper strap picks address group 0x6c or 0x70
// - Address in upper seven bits, rw in lsb
// - Default slot equals strap address offset
// - Slot source bit selects register slot field
// - Standard stereo: slot 0 right, 1 left
// - Justified stereo: slot 0 left, 1 right
// - Works at 100 kHz and 400 kHz
// - Slave only, never stretches the clock
// - Bytes msb first, receiver acknowledges each
// - Start and stop are data edges, clock high
// - Data changes only while clock low
// - Device acknowledges address and received bytes
// - Unlimited bytes between start and stop
// - Master writes control, reads status registers
// - Write: register address then sequential data
// - Read: repeated start, bytes from register onward
`ifndef AMPCTL_DEFINES_VH
`define AMPCTL_DEFINES_VH
`define AMPCTL_ADDR_GROUP_LOW 7'h6c
`define AMPCTL_ADDR_GROUP_HIGH 7'h70
`define AMPCTL_STRAP_GND 2'h0
`define AMPCTL_STRAP_RES_GND 2'h1
`define AMPCTL_STRAP_RES_SUP 2'h2
`define AMPCTL_STRAP_SUP 2'h3
`define AMPCTL_REG_FORMAT 8'h02
`define AMPCTL_REG_SLOT 8'h03
`define AMPCTL_REG_STATUS 8'h04
`define AMPCTL_SLOT_SRC_BIT 6
`define AMPCTL_FMT_STANDARD 3'h4
`define AMPCTL_FMT_LEFT_JUST 3'h5
`define AMPCTL_FMT_RIGHT_JUST 3'h6
`define AMPCTL_READY_MS 12
`define AMPCTL_CLK_KHZ 50000
`define AMPCTL_READY_CYCLES (`AMPCTL_READY_MS * `AMPCTL_CLK_KHZ)
`define AMPCTL_REG_DEPTH 16
`endif

// [logic/ampctl_regmem.v]
// Small register memory with registered read data
`include "ampctl_defines.vh"
module ampctl_regmem
(
   // Clock and reset
   input wire clock_in,
   input wire reset_n_in,
   // Write port
   input wire wr_en_in,
   input wire [3:0] wr_addr_in,
   input wire [7:0] wr_data_in,
   // Read port
   input wire [3:0] rd_addr_in,
   output reg [7:0] rd_data_out
);
   reg [7:0] mem_ff [0:`AMPCTL_REG_DEPTH-1];
   genvar gi;
   generate
      for (gi = 0; gi < `AMPCTL_REG_DEPTH; gi = gi + 1)
      begin : g_word
         always @(posedge clock_in or negedge reset_n_in)
         begin
            if (!reset_n_in)
               mem_ff[gi] <= 8'h00;
            else if (wr_en_in && wr_addr_in == gi)
               mem_ff[gi] <= wr_data_in;
         end
      end
   endgenerate
   always @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         rd_data_out <= 8'h00;
      else
         rd_data_out <= mem_ff[rd_addr_in];
   end
endmodule

// [logic/ampctl_port.v]
// Two-wire slave control port with strap address decode and slot select
`include "ampctl_defines.vh"
module ampctl_port
#(
   parameter READY_CYCLES = `AMPCTL_READY_CYCLES
)
(
   // Clock and reset
   input wire clock_in,
   input wire reset_n_in,
   // Address straps, four-level code each
   input wire [1:0] addr_strap_high_in,
   input wire [1:0] addr_strap_low_in,
   // Bus pins
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_out,
   // Status
   output reg ready_out,
   output reg [6:0] bus_slave_address_out,
   output reg [3:0] active_slot_out,
   output reg slot_is_left_out,
   // Control values seen by the audio side
   output reg [7:0] format_reg_out,
   output reg [7:0] slot_reg_out
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_ACK = 3'h2;
   localparam ST_RX = 3'h3;
   localparam ST_TX = 3'h4;
   localparam ST_MACK = 3'h5;
   reg scl_s1_ff, scl_ff, scl_d_ff, sda_s1_ff, sda_ff, sda_d_ff;
   reg [3:0] strap_s1_ff, strap_ff;
   reg [1:0] strap_wait_ff;
   reg [25:0] ready_cnt_ff;
   reg ready_ff, strap_done_ff;
   reg [6:0] dev_addr_ff;
   reg [2:0] def_slot_ff;
   reg [2:0] state_ff;
   reg [3:0] bit_cnt_ff;
   reg [7:0] shift_ff;
   reg [7:0] reg_ptr_ff;
   reg have_ptr_ff, rd_mode_ff;
   reg drive_low_ff;
   reg wr_en_ff;
   reg [7:0] wr_data_ff;
   reg [3:0] wr_addr_ff;
   wire [7:0] mem_rd;
   wire scl_rise = scl_ff && !scl_d_ff;
   wire scl_fall = !scl_ff && scl_d_ff;
   wire start_det = scl_ff && scl_d_ff && !sda_ff && sda_d_ff;
   wire stop_det = scl_ff && scl_d_ff && sda_ff && !sda_d_ff;
   wire [3:0] slot_sel = format_reg_out[`AMPCTL_SLOT_SRC_BIT] ? slot_reg_out[3:0] : {1'b0, def_slot_ff};
   wire [7:0] status_byte = {ready_ff, 1'b0, rd_mode_ff, 1'b0, slot_sel};
   ampctl_regmem u_mem
   (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .wr_en_in(wr_en_ff),
      .wr_addr_in(wr_addr_ff),
      .wr_data_in(wr_data_ff),
      .rd_addr_in(reg_ptr_ff[3:0]),
      .rd_data_out(mem_rd)
   );
   // Synchronise bus pins
   always @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         scl_s1_ff <= 1'b1;
         scl_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         strap_s1_ff <= 4'h0;
         strap_ff <= 4'h0;
      end
      else
      begin
         strap_s1_ff <= {addr_strap_high_in, addr_strap_low_in};
         strap_ff <= strap_s1_ff;
         scl_s1_ff <= scl_in;
         scl_ff <= scl_s1_ff;
         scl_d_ff <= scl_ff;
         sda_s1_ff <= sda_in;
         sda_ff <= sda_s1_ff;
         sda_d_ff <= sda_ff;
      end
   end
   // Power-up ready timer and strap capture
   always @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ready_cnt_ff <= 26'h0;
         ready_ff <= 1'b0;
         strap_done_ff <= 1'b0;
         strap_wait_ff <= 2'h0;
         dev_addr_ff <= 7'h00;
         def_slot_ff <= 3'h0;
      end
      else
      begin
         if (!strap_done_ff)
         begin
            // Wait until the synchronised strap copy is valid
            strap_wait_ff <= strap_wait_ff + 2'h1;
            if (strap_wait_ff == 2'h2)
            begin
               strap_done_ff <= 1'b1;
               dev_addr_ff <= (strap_ff[3:2] == `AMPCTL_STRAP_GND) ?
                  (`AMPCTL_ADDR_GROUP_LOW | {5'h0, strap_ff[1:0]}) :
                  (`AMPCTL_ADDR_GROUP_HIGH | {5'h0, strap_ff[1:0]});
               def_slot_ff <= {strap_ff[3:2] != `AMPCTL_STRAP_GND, strap_ff[1:0]};
            end
         end
         if (!ready_ff)
         begin
            if (ready_cnt_ff == READY_CYCLES[25:0] - 26'h1)
               ready_ff <= 1'b1;
            ready_cnt_ff <= ready_cnt_ff + 26'h1;
         end
      end
   end
   // Slave protocol engine, sampled on clock rise, driven after clock fall
   always @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         reg_ptr_ff <= 8'h00;
         have_ptr_ff <= 1'b0;
         rd_mode_ff <= 1'b0;
         drive_low_ff <= 1'b0;
         wr_en_ff <= 1'b0;
         wr_data_ff <= 8'h00;
         wr_addr_ff <= 4'h0;
      end
      else
      begin
         wr_en_ff <= 1'b0;
         if (!ready_ff || stop_det)
         begin
            state_ff <= ST_IDLE;
            drive_low_ff <= 1'b0;
         end
         else if (start_det)
         begin
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            have_ptr_ff <= 1'b0;
            drive_low_ff <= 1'b0;
         end
         else
         begin
            case (state_ff)
               ST_IDLE:
                  drive_low_ff <= 1'b0;
               ST_ADDR, ST_RX:
               begin
                  if (scl_rise)
                  begin
                     shift_ff <= {shift_ff[6:0], sda_ff};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
                  // A byte is complete only after eight rises, not at the fall that follows a start
                  if (scl_fall && bit_cnt_ff == 4'h8 && state_ff == ST_ADDR && shift_ff[7:1] != dev_addr_ff)
                     state_ff <= ST_IDLE;
                  else if (scl_fall && bit_cnt_ff == 4'h8)
                  begin
                     drive_low_ff <= 1'b1;
                     state_ff <= ST_ACK;
                     if (state_ff == ST_ADDR)
                        rd_mode_ff <= shift_ff[0];
                     else if (!have_ptr_ff)
                     begin
                        reg_ptr_ff <= shift_ff;
                        have_ptr_ff <= 1'b1;
                     end
                     else
                     begin
                        wr_en_ff <= 1'b1;
                        wr_addr_ff <= reg_ptr_ff[3:0];
                        wr_data_ff <= shift_ff;
                        reg_ptr_ff <= reg_ptr_ff + 8'h01;
                     end
                  end
               end
               ST_ACK:
                  if (scl_fall)
                  begin
                     bit_cnt_ff <= 4'h0;
                     if (rd_mode_ff)
                     begin
                        shift_ff <= (reg_ptr_ff == `AMPCTL_REG_STATUS) ? status_byte : mem_rd;
                        drive_low_ff <= (reg_ptr_ff == `AMPCTL_REG_STATUS) ? !status_byte[7] : !mem_rd[7];
                        reg_ptr_ff <= reg_ptr_ff + 8'h01;
                        state_ff <= ST_TX;
                     end
                     else
                     begin
                        drive_low_ff <= 1'b0;
                        state_ff <= ST_RX;
                     end
                  end
               ST_TX:
                  if (scl_fall)
                  begin
                     if (bit_cnt_ff == 4'h7)
                     begin
                        drive_low_ff <= 1'b0;
                        state_ff <= ST_MACK;
                     end
                     else
                     begin
                        drive_low_ff <= !shift_ff[6];
                        shift_ff <= {shift_ff[6:0], 1'b0};
                     end
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               ST_MACK:
                  if (scl_rise)
                     state_ff <= sda_ff ? ST_IDLE : ST_ACK;
               default:
                  state_ff <= ST_IDLE;
            endcase
         end
      end
   end
   // Registered outputs; the port only pulls low, never holds the clock
   always @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
         ready_out <= 1'b0;
         bus_slave_address_out <= 7'h00;
         active_slot_out <= 4'h0;
         slot_is_left_out <= 1'b0;
         format_reg_out <= 8'h00;
         slot_reg_out <= 8'h00;
      end
      else
      begin
         sda_out <= 1'b0;
         sda_oe_out <= drive_low_ff;
         ready_out <= ready_ff;
         bus_slave_address_out <= dev_addr_ff;
         active_slot_out <= slot_sel;
         if (wr_en_ff && wr_addr_ff == `AMPCTL_REG_FORMAT)
            format_reg_out <= wr_data_ff;
         if (wr_en_ff && wr_addr_ff == `AMPCTL_REG_SLOT)
            slot_reg_out <= wr_data_ff;
         if (format_reg_out[2:0] == `AMPCTL_FMT_STANDARD)
            slot_is_left_out <= (slot_sel == 4'h1);
         else
            slot_is_left_out <= (slot_sel == 4'h0);
      end
   end
endmodule

// [tb/ampctl_monitor.sv]
// Checker for the control port outputs
module ampctl_monitor
#(
   parameter READY_CYCLES = 50
)
(
   // Clock and reset
   input wire clock_in,
   input wire reset_n_in,
   // Straps and bus
   input wire [1:0] addr_strap_high_in,
   input wire [1:0] addr_strap_low_in,
   input wire scl_in,
   input wire sda_out,
   input wire sda_oe_out,
   // Status
   input wire ready_out,
   input wire [6:0] bus_slave_address_out,
   input wire [3:0] active_slot_out,
   input wire slot_is_left_out,
   input wire [7:0] format_reg_out,
   input wire [7:0] slot_reg_out
);
   timeunit 1ns;
   timeprecision 1ps;
   reg got_ff;
   reg [3:0] strap_ff;
   int cnt_ff;
   wire [6:0] exp_addr = (strap_ff[3:2] == 2'h0 ? 7'h6c : 7'h70) + {5'h0, strap_ff[1:0]};
   wire [3:0] exp_slot = {1'b0, strap_ff[3:2] != 2'h0, strap_ff[1:0]};
   // Strap copy and cycle count since reset
   always @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         got_ff <= 1'b0;
         strap_ff <= 4'h0;
         cnt_ff <= 0;
      end
      else
      begin
         got_ff <= 1'b1;
         if (!got_ff)
            strap_ff <= {addr_strap_high_in, addr_strap_low_in};
         if (cnt_ff < READY_CYCLES + 9)
            cnt_ff <= cnt_ff + 1;
      end
   end
   default clocking dc @(posedge clock_in);
   endclocking
   default disable iff (!reset_n_in);
   sequence s_steady;
      ready_out && $stable(format_reg_out) && $stable(slot_reg_out);
   endsequence
   sequence s_held;
      s_steady [*3];
   endsequence
   AST_READY_EARLY: assert property (ready_out |-> cnt_ff >= READY_CYCLES)
      else $error("ready too early");
   AST_READY_LATE: assert property (cnt_ff >= READY_CYCLES + 4 |-> ready_out)
      else $error("ready too late");
   AST_QUIET: assert property (!ready_out |-> !sda_oe_out)
      else $error("bus driven before ready");
   AST_OPEN_DRAIN: assert property (sda_oe_out |-> !sda_out)
      else $error("data line driven high");
   AST_ADDR: assert property (ready_out |-> bus_slave_address_out == exp_addr)
      else $error("wrong bus address");
   AST_SLOT_DEF: assert property (s_held ##0 !format_reg_out[6] |-> active_slot_out == exp_slot)
      else $error("wrong default slot");
   AST_SLOT_REG: assert property (s_held ##0 format_reg_out[6] |-> active_slot_out == slot_reg_out[3:0])
      else $error("wrong register slot");
   AST_LEFT_STD: assert property (s_held ##0 format_reg_out[2:0] == 3'h4 && active_slot_out < 4'h2
      |-> slot_is_left_out == active_slot_out[0]) else $error("wrong channel in standard framing");
   AST_LEFT_JUST: assert property (s_held ##0 (format_reg_out[2:0] == 3'h5 || format_reg_out[2:0] == 3'h6)
      && active_slot_out < 4'h2 |-> slot_is_left_out != active_slot_out[0]) else $error("wrong justified channel");
   AST_ACK_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data changed with clock high");
   AST_ACK_HELD: assert property ($rose(sda_oe_out) |-> sda_oe_out [*8])
      else $error("acknowledge too short");
endmodule
bind ampctl_port ampctl_monitor #(.READY_CYCLES(READY_CYCLES)) i_mon (.clock_in(clock_in), .reset_n_in(reset_n_in),
   .addr_strap_high_in(addr_strap_high_in), .addr_strap_low_in(addr_strap_low_in), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .ready_out(ready_out), .bus_slave_address_out(bus_slave_address_out),
   .active_slot_out(active_slot_out), .slot_is_left_out(slot_is_left_out), .format_reg_out(format_reg_out),
   .slot_reg_out(slot_reg_out));

// [tb/ampctl_master.sv]
// Two-wire bus master model driving the clock and a data pull-down
module ampctl_master
(
   // Clock
   input wire clock_in,
   // Bus
   input wire sda_bus_in,
   output logic scl_out,
   output logic sda_low_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   // Clock low long enough for the slave answer
   task automatic bit_io(input logic b, output logic r);
      scl_out <= 1'b0;
      tick(16);
      sda_low_out <= !b;
      tick(50);
      scl_out <= 1'b1;
      tick(16);
      r = sda_bus_in;
      tick(16);
   endtask
   task automatic start_c();
      scl_out <= 1'b0;
      tick(16);
      sda_low_out <= 1'b0;
      tick(50);
      scl_out <= 1'b1;
      tick(40);
      sda_low_out <= 1'b1;
      tick(40);
   endtask
   task automatic stop_c();
      scl_out <= 1'b0;
      tick(16);
      sda_low_out <= 1'b1;
      tick(50);
      scl_out <= 1'b1;
      tick(40);
      sda_low_out <= 1'b0;
      tick(40);
   endtask
   task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(nine, ack);
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the two-wire control port
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] st_hi = 2'h0;
   logic [1:0] st_lo = 2'h0;
   wire scl, m_low, sda_bus, sda_o, sda_oe, rdy, left;
   wire [6:0] adr;
   wire [3:0] slot;
   wire [7:0] fmt, sreg;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int seed = 32'hb8d6;
   int r;
   logic [7:0] exp_q[$];
   string nm_q[$];
   logic [7:0] seen, q;
   logic [6:0] dev;
   logic a, sb;
   event seen_ev;
   assign sda_bus = !(m_low || (sda_oe && !sda_o));
   initial forever #10 clk = ~clk;
   ampctl_port #(.READY_CYCLES(50)) i_dut (.clock_in(clk), .reset_n_in(reset_n), .addr_strap_high_in(st_hi),
      .addr_strap_low_in(st_lo), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .ready_out(rdy), .bus_slave_address_out(adr), .active_slot_out(slot), .slot_is_left_out(left),
      .format_reg_out(fmt), .slot_reg_out(sreg));
   ampctl_master i_mst (.clock_in(clk), .sda_bus_in(sda_bus), .scl_out(scl), .sda_low_out(m_low));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(string n, logic [7:0] s, logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic note(string n, logic [7:0] e, logic [7:0] s);
      exp_q.push_back(e);
      nm_q.push_back(n);
      seen = s;
      -> seen_ev;
      @(negedge clk);
   endtask
   initial forever
   begin
      @(seen_ev);
      check(nm_q.pop_front(), seen, exp_q.pop_front());
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 60000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic do_reset(logic [3:0] s);
      @(posedge clk);
      {st_hi, st_lo} <= s;
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (60) @(posedge clk);
      dev = (s[3:2] != 2'h0 ? 7'h70 : 7'h6c) + {5'h0, s[1:0]};
   endtask
   task automatic send(string n, logic [7:0] d, logic ea);
      i_mst.byte_io(d, 1'b1, q, a);
      note(n, {7'h0, ea}, {7'h0, a});
   endtask
   task automatic recv(logic last, logic [7:0] e);
      i_mst.byte_io(8'hff, last, q, a);
      note("read", e, q);
   endtask
   task automatic wreg(logic [7:0] d0, logic [7:0] d1);
      i_mst.start_c();
      send("aw", {dev, 1'b0}, 1'b0);
      send("ptr", 8'h02, 1'b0);
      send("d0", d0, 1'b0);
      send("d1", d1, 1'b0);
      i_mst.stop_c();
      repeat (5) @(posedge clk);
      note("fmt", d0, fmt);
      note("sreg", d1, sreg);
   endtask
   initial
   begin
      for (int k = 0; k < 16; k++)
      begin
         do_reset(k[3:0]);
         note("addr", {1'b0, dev}, {1'b0, adr});
         note("slot", {5'h0, k > 3, k[1:0]}, {4'h0, slot});
      end
      note("ready", 8'h01, {7'h0, rdy});
      $display("test straps done");
      r = $random(seed);
      sb = r[4];
      do_reset(r[3:0]);
      {st_hi, st_lo} <= ~r[3:0];
      repeat (4) @(posedge clk);
      note("hold", {1'b0, dev}, {1'b0, adr});
      for (int f = 4; f < 7; f++)
      begin
         wreg(8'h40 | f[7:0], {7'h0, sb});
         note("act", {7'h0, sb}, {4'h0, slot});
         note("left", {7'h0, sb ^ (f != 4)}, {7'h0, left});
      end
      $display("test write done");
      i_mst.start_c();
      send("aw", {dev, 1'b0}, 1'b0);
      send("ptr", 8'h02, 1'b0);
      i_mst.start_c();
      send("ar", {dev, 1'b1}, 1'b0);
      recv(1'b0, 8'h46);
      recv(1'b0, {7'h0, sb});
      recv(1'b1, 8'ha0 | {7'h0, sb});
      i_mst.stop_c();
      $display("test read done");
      i_mst.start_c();
      send("nak", {dev ^ 7'h01, 1'b0}, 1'b1);
      send("ign", 8'h02, 1'b1);
      i_mst.stop_c();
      note("keep", 8'h46, fmt);
      $display("test wrong address done");
      report_and_stop();
   end
endmodule
